// *** pkg/did_pkg.sv ***
// Shared types and constants for the dual-issue in-order dispatch block.
// Assumes one core clock and a synchronous active-high reset.
package did_pkg;
  localparam int NUM_THREADS = 2;
  localparam int NUM_PORTS = 2;
  localparam int QUEUE_DEPTH = 8;
  localparam int TAG_W = 8;
  localparam logic [1:0] HALF_PTR_RST = 2'h0;
  localparam logic [2:0] HALF_CNT_RST = 3'h0;
  localparam logic THREAD_RST = 1'h0;
  // Extra load-to-use latency in cycles
  localparam int LOAD_USE_EXTRA = 0;

  typedef enum logic [3:0] {
    OP_ALU, OP_SHIFT, OP_LOAD, OP_STORE, OP_BIT, OP_JUMP, OP_LEA, OP_STACK,
    OP_SIMD_ALU, OP_SIMD_ALU64, OP_SHUFFLE, OP_FMUL, OP_DIV, OP_IMUL, OP_FADD,
    OP_FADD_PS
  } did_class_type;

  typedef enum logic [3:0] {
    U_NONE, U_INT_INTEGER_ALU_FIRST, U_SHIFT, U_LDST, U_INT_INTEGER_ALU_SECOND, U_BITP, U_JUMP, U_AGU1,
    U_SIMD_INTEGER_ALU_FIRST, U_SHUF, U_FMUL, U_DIV, U_SIMD_INTEGER_ALU_SECOND, U_FADD
  } did_unit_type;

  typedef struct packed {
    logic valid;
    did_class_type cls;
    logic mem_op;
    logic fp_side;
    logic may_except;
    logic ready;
    logic [TAG_W-1:0] tag;
  } did_op_type;

  typedef struct packed {
    logic valid;
    logic thread;
    did_unit_type unit;
    logic wide128;
    logic mem_op;
    logic fwd_store;
    logic [TAG_W-1:0] tag;
  } did_issue_type;
endpackage

// *** hdl/did_dispatch.sv ***
// Front-end queue, thread picker and two-port issue for an in-order core.
// Assumes decoders present one op each per cycle and clusters accept issues.
module did_dispatch
  import did_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire did_op_type dec0_op,
  input wire logic dec0_thread,
  input wire did_op_type dec1_op,
  input wire logic dec1_thread,
  output logic [NUM_THREADS-1:0] thread_room,
  input wire logic [NUM_THREADS-1:0] thread_stall,
  input wire logic store_pending,
  output did_issue_type issue0,
  output did_issue_type issue1
);
  localparam int HALF = DEPTH / NUM_THREADS;
  localparam int PW = $clog2(HALF);

  did_op_type mem_reg [NUM_THREADS][HALF];
  logic [PW-1:0] wr_ptr_reg [NUM_THREADS];
  logic [PW-1:0] rd_ptr_reg [NUM_THREADS];
  logic [PW:0] cnt_reg [NUM_THREADS];
  logic last_thread_reg;
  did_issue_type issue0_reg, issue1_reg;

  logic [1:0] wr_cnt [NUM_THREADS];
  logic [1:0] rd_cnt [NUM_THREADS];
  logic pick_thread;
  did_op_type head0, head1;
  logic head0_ok, head1_ok;
  logic [1:0] n_issue;
  did_unit_type u0_p0, u0_p1, u1_p0, u1_p1;
  logic swap;
  logic pair_ok;
  logic acc0, acc1;
  logic [NUM_THREADS-1:0] thread_ok;
  did_issue_type issue0_next, issue1_next;

  function automatic did_unit_type unit_on(input did_class_type c, input logic port);
    did_unit_type u;
    u = U_NONE;
    unique case (c)
      OP_ALU: u = port ? U_INT_INTEGER_ALU_SECOND : U_INT_INTEGER_ALU_FIRST;
      OP_SHIFT: u = port ? U_NONE : U_SHIFT;
      OP_LOAD, OP_STORE: u = port ? U_NONE : U_LDST;
      OP_BIT: u = port ? U_BITP : U_NONE;
      OP_JUMP: u = port ? U_JUMP : U_NONE;
      OP_LEA, OP_STACK: u = port ? U_AGU1 : U_NONE;
      OP_SIMD_ALU: u = port ? U_SIMD_INTEGER_ALU_SECOND : U_SIMD_INTEGER_ALU_FIRST;
      OP_SIMD_ALU64: u = port ? U_NONE : U_SIMD_INTEGER_ALU_FIRST;
      OP_SHUFFLE: u = port ? U_NONE : U_SHUF;
      OP_FMUL, OP_IMUL: u = port ? U_NONE : U_FMUL;
      OP_DIV: u = port ? U_NONE : U_DIV;
      OP_FADD, OP_FADD_PS: u = port ? U_FADD : U_NONE;
    endcase
    return u;
  endfunction

  // fp add with memory on either port
  function automatic did_unit_type bind_unit(input did_op_type o, input logic port);
    did_unit_type u;
    u = unit_on(o.cls, port);
    if (o.mem_op && (o.cls == OP_FADD || o.cls == OP_FADD_PS) && !port) begin
      u = U_FADD;
    end
    return u;
  endfunction

  // Datapath width follows the op class, not only the decoder's fp hint
  function automatic logic path_wide(input did_op_type o);
    logic w;
    w = o.fp_side;
    if (o.cls inside {OP_SIMD_ALU, OP_SIMD_ALU64, OP_SHUFFLE}) begin
      w = 1'b1;
    end
    if (o.cls == OP_FADD_PS) begin
      w = 1'b1;
    end else if (o.cls == OP_FADD) begin
      w = 1'b0;
    end
    return w;
  endfunction

  function automatic did_issue_type mk_issue(input did_op_type o, input logic t,
                                             input did_unit_type u, input logic sp);
    did_issue_type r;
    r.valid = 1'b1;
    r.thread = t;
    r.unit = u;
    r.wide128 = path_wide(o);
    r.mem_op = o.mem_op;
    r.fwd_store = sp && (o.cls == OP_LOAD) && !o.fp_side;
    r.tag = o.tag;
    return r;
  endfunction

  // two writes max
  // A full half refuses a write rather than overwriting its oldest op
  always_comb begin
    acc0 = dec0_op.valid && (int'(cnt_reg[dec0_thread]) < HALF);
    acc1 = dec1_op.valid && (int'(cnt_reg[dec1_thread])
         + ((acc0 && dec0_thread == dec1_thread) ? 1 : 0) < HALF);
    for (int t = 0; t < NUM_THREADS; t++) begin
      wr_cnt[t] = 2'((acc0 && dec0_thread == t[0]) ? 1 : 0)
                + 2'((acc1 && dec1_thread == t[0]) ? 1 : 0);
      thread_room[t] = (int'(cnt_reg[t]) + 2) <= HALF;
    end
  end

  always_comb begin
    for (int t = 0; t < NUM_THREADS; t++) begin
      thread_ok[t] = (cnt_reg[t] != '0) && !thread_stall[t]
                   && mem_reg[t][rd_ptr_reg[t]].ready;
    end
  end

  // fairness plus readiness
  // Alternating when both can go keeps one busy thread from starving the other
  always_comb begin
    if (thread_ok == 2'h3) begin
      pick_thread = ~last_thread_reg;
    end else begin
      pick_thread = thread_ok[1];
    end
  end

  always_comb begin
    logic [PW-1:0] p1;
    p1 = rd_ptr_reg[pick_thread] + PW'(1);
    head0 = mem_reg[pick_thread][rd_ptr_reg[pick_thread]];
    head1 = mem_reg[pick_thread][p1];
    head0_ok = (cnt_reg[pick_thread] != '0) && head0.ready && !thread_stall[pick_thread];
    // safe integer bypass; zero load-use wait
    head1_ok = head0_ok && (cnt_reg[pick_thread] > 1) && head1.ready
             && (!head0.may_except || !head1.fp_side);
    u0_p0 = bind_unit(head0, 1'b0);
    u0_p1 = bind_unit(head0, 1'b1);
    u1_p0 = bind_unit(head1, 1'b0);
    u1_p1 = bind_unit(head1, 1'b1);
    // Head takes port 0 when it can; it moves to port 1 when that
    // lets a port-0-only follower go in the same cycle
    swap = 1'b0;
    pair_ok = 1'b0;
    if (u0_p0 == U_NONE) begin
      swap = 1'b1;
      pair_ok = (u1_p0 != U_NONE);
    end else if (u1_p1 != U_NONE) begin
      pair_ok = 1'b1;
    end else if (head1_ok && u0_p1 != U_NONE && u1_p0 != U_NONE) begin
      swap = 1'b1;
      pair_ok = 1'b1;
    end
    n_issue = 2'h0;
    if (head0_ok) begin
      n_issue = 2'h1;
      if (head1_ok && pair_ok) begin
        n_issue = 2'h2;
      end
    end
    for (int t = 0; t < NUM_THREADS; t++) begin
      rd_cnt[t] = (t[0] == pick_thread) ? n_issue : 2'h0;
    end
  end

  // Write side advances by the ops accepted this cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        wr_ptr_reg[t] <= PW'(HALF_PTR_RST);
      end
    end else begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        wr_ptr_reg[t] <= wr_ptr_reg[t] + PW'(wr_cnt[t]);
      end
    end
  end

  // Read side advances by the ops issued this cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        rd_ptr_reg[t] <= PW'(HALF_PTR_RST);
      end
    end else begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        rd_ptr_reg[t] <= rd_ptr_reg[t] + PW'(rd_cnt[t]);
      end
    end
  end

  // Occupancy is one bit wider than a pointer so a full half is visible
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        cnt_reg[t] <= (PW+1)'(HALF_CNT_RST);
      end
    end else begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        cnt_reg[t] <= cnt_reg[t] + (PW+1)'(wr_cnt[t]) - (PW+1)'(rd_cnt[t]);
      end
    end
  end

  // Writes land in order: decoder 0 first when both hit one thread
  always_ff @(posedge mclk) begin
    if (acc0) begin
      mem_reg[dec0_thread][wr_ptr_reg[dec0_thread]] <= dec0_op;
    end
    if (acc1) begin
      mem_reg[dec1_thread][wr_ptr_reg[dec1_thread]
        + PW'((acc0 && dec0_thread == dec1_thread) ? 1 : 0)] <= dec1_op;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      last_thread_reg <= THREAD_RST;
    end else if (n_issue != 2'h0) begin
      last_thread_reg <= pick_thread;
    end
  end

  always_comb begin
    issue0_next = '0;
    issue1_next = '0;
    if (n_issue != 2'h0) begin
      if (!swap) begin
        issue0_next = mk_issue(head0, pick_thread, u0_p0, store_pending);
      end else begin
        issue1_next = mk_issue(head0, pick_thread, u0_p1, store_pending);
      end
    end
    if (n_issue == 2'h2) begin
      if (!swap) begin
        issue1_next = mk_issue(head1, pick_thread, u1_p1, store_pending);
      end else begin
        issue0_next = mk_issue(head1, pick_thread, u1_p0, store_pending);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      issue0_reg <= '0;
    end else begin
      issue0_reg <= issue0_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      issue1_reg <= '0;
    end else begin
      issue1_reg <= issue1_next;
    end
  end

  assign issue0 = issue0_reg;
  assign issue1 = issue1_reg;
endmodule

// *** tb/did_dispatch_sva.sv ***
// Port checker for the dispatch block.
// Assumes it is bound to did_dispatch on one clock.
module did_chk
  import did_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [NUM_THREADS-1:0] thread_room,
  input wire logic [NUM_THREADS-1:0] thread_stall,
  input wire did_issue_type issue0,
  input wire did_issue_type issue1
);
  logic [1:0] stall_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Issue is decided on the edge before the pulse
  always_ff @(posedge mclk) begin
    stall_reg <= thread_stall;
  end
  AST_P0_UNIT: assert property (issue0.valid |-> issue0.unit inside {U_INT_INTEGER_ALU_FIRST,
    U_SHIFT, U_LDST, U_SIMD_INTEGER_ALU_FIRST, U_SHUF, U_FMUL, U_DIV} || issue0.unit == U_FADD
    && issue0.mem_op) else $error("bad unit on port 0");
  AST_P1_UNIT: assert property (issue1.valid |-> issue1.unit inside {U_INT_INTEGER_ALU_SECOND,
    U_BITP, U_JUMP, U_AGU1, U_SIMD_INTEGER_ALU_SECOND, U_FADD}) else $error("bad unit on port 1");
  AST_ONE_THREAD: assert property (issue0.valid && issue1.valid |->
    issue0.thread == issue1.thread) else $error("mixed threads");
  AST_NO_SPLIT: assert property (issue0.valid && issue1.valid |->
    issue0.tag != issue1.tag) else $error("op split over ports");
  AST_SIMD_WIDE: assert property (issue0.valid && issue0.unit inside {U_SIMD_INTEGER_ALU_FIRST,
    U_SHUF} |-> issue0.wide128) else $error("narrow simd");
  AST_FWD: assert property (issue0.valid && issue0.fwd_store |->
    issue0.unit == U_LDST && issue0.mem_op) else $error("bad forward");
  AST_ROOM_RST: assert property ($fell(rst) |-> thread_room == 2'h3)
    else $error("room after reset");
  AST_STALL: assert property (issue0.valid |-> !stall_reg[issue0.thread])
    else $error("stalled thread issued");
  COV_DUAL: cover property (issue0.valid && issue1.valid);
  COV_FWD: cover property (issue0.valid && issue0.fwd_store);
  COV_JUMP: cover property (issue1.valid && issue1.unit == U_JUMP);
endmodule
bind did_dispatch did_chk did_chk_inst (.mclk(mclk), .rst(rst), .thread_room(thread_room),
  .thread_stall(thread_stall), .issue0(issue0), .issue1(issue1));

// *** tb/did_cluster_model.sv ***
// Execution cluster model: logs each op issued per port.
// Assumes issue pulses last one cycle.
module did_cluster_model
  import did_pkg::*;
(
  input wire logic mclk,
  input wire did_issue_type issue0,
  input wire did_issue_type issue1
);
  timeunit 1ns;
  timeprecision 1ns;
  did_issue_type q0[$];
  did_issue_type q1[$];
  // Clusters never stall, so each pulse is taken at once
  always @(posedge mclk) begin
    if (issue0.valid) q0.push_back(issue0);
    if (issue1.valid) q1.push_back(issue1);
  end
endmodule

// *** tb/tb_top.sv ***
// Testbench for the dispatch block.
// Assumes the cluster model logs every issue.
module tb_top
  import did_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, dec0_thread, dec1_thread, store_pending, p;
  logic [1:0] thread_room, thread_stall;
  did_op_type dec0_op, dec1_op, o;
  did_issue_type issue0, issue1, got;
  int n_fail, n_checks;
  // Port bit and unit for each op class
  localparam logic [4:0] MAP [16] = '{5'h01, 5'h02, 5'h03, 5'h03, 5'h15, 5'h16, 5'h17, 5'h17,
    5'h08, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0a, 5'h1d, 5'h1d};
  did_dispatch did_dispatch_inst (.mclk(mclk), .rst(rst), .dec0_op(dec0_op),
    .dec0_thread(dec0_thread), .dec1_op(dec1_op), .dec1_thread(dec1_thread),
    .thread_room(thread_room), .thread_stall(thread_stall), .store_pending(store_pending),
    .issue0(issue0), .issue1(issue1));
  did_cluster_model did_cluster_model_inst (.mclk(mclk), .issue0(issue0), .issue1(issue1));
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  function automatic did_op_type mk(did_class_type c, logic [7:0] t, logic m);
    mk = '{1'b1, c, m, c >= OP_SIMD_ALU, 1'b0, 1'b1, t};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic send(did_op_type a, did_op_type b, logic t);
    @(posedge mclk);
    dec0_op <= a;
    dec1_op <= b;
    dec0_thread <= t;
    dec1_thread <= t;
    @(posedge mclk);
    dec0_op <= '0;
    dec1_op <= '0;
  endtask
  task automatic flush;
    did_cluster_model_inst.q0.delete();
    did_cluster_model_inst.q1.delete();
  endtask
  // Oldest logged port 0 issue, else oldest port 1 issue; p tells which port took it
  task automatic take;
    repeat (4) @(posedge mclk);
    p = did_cluster_model_inst.q0.size() == 0;
    if (p) got = did_cluster_model_inst.q1.pop_front();
    else got = did_cluster_model_inst.q0.pop_front();
  endtask
  task automatic t_ports;
    for (int c = 0; c < 16; c++) begin
      send(mk(did_class_type'(c), c[7:0], 1'b0), '0, 1'b0);
      take();
      chk({p, got.unit}, MAP[c]);
      if (c >= 14) chk(got.wide128, c == 15);
    end
  endtask
  task automatic t_mem;
    store_pending <= 1'b1;
    send(mk(OP_LOAD, 8'h50, 1'b1), '0, 1'b0);
    take();
    chk({got.fwd_store, got.mem_op, p}, 3'h6);
    store_pending <= 1'b0;
    send(mk(OP_FMUL, 8'h51, 1'b1), '0, 1'b0);
    take();
    chk({got.unit, got.mem_op}, {U_FMUL, 1'b1});
    send(mk(OP_FADD, 8'h52, 1'b1), '0, 1'b0);
    take();
    chk({p, got.unit}, {1'b0, U_FADD});
  endtask
  task automatic pair(did_op_type a, did_op_type b, logic [1:0] e);
    send(a, b, 1'b1);
    #1;
    for (int i = 0; i < 8 && issue0.valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({issue0.valid, issue1.valid}, e);
    @(posedge mclk);
    #1;
    chk(issue0.valid, !e[0]);
    repeat (3) @(posedge mclk);
    flush();
  endtask
  task automatic t_threads;
    thread_stall <= 2'h1;
    send(mk(OP_ALU, 8'h60, 1'b0), mk(OP_ALU, 8'h61, 1'b0), 1'b0);
    #1;
    chk(thread_room, 2'h3);
    send(mk(OP_ALU, 8'h62, 1'b0), '0, 1'b0);
    send(mk(OP_BIT, 8'h70, 1'b0), '0, 1'b1);
    #1;
    chk(thread_room, 2'h2);
    take();
    chk(got.thread, 1'b1);
    thread_stall <= 2'h0;
    repeat (8) @(posedge mclk);
    chk(did_cluster_model_inst.q0.size() + did_cluster_model_inst.q1.size(), 3);
    flush();
  endtask
  task automatic results;
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rst, dec0_thread, dec1_thread, store_pending, thread_stall} = 6'h20;
    dec0_op = '0;
    dec1_op = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_ports();
    t_mem();
    pair(mk(OP_ALU, 8'h40, 1'b0), mk(OP_BIT, 8'h41, 1'b0), 2'h3);
    pair(mk(OP_SHIFT, 8'h42, 1'b0), mk(OP_LOAD, 8'h43, 1'b0), 2'h2);
    o = mk(OP_DIV, 8'h44, 1'b0);
    o.may_except = 1'b1;
    pair(o, mk(OP_ALU, 8'h45, 1'b0), 2'h3);
    pair(mk(OP_ALU, 8'h46, 1'b0), mk(OP_SHIFT, 8'h47, 1'b0), 2'h3);
    t_threads();
    results();
  end
  // Whole run is under two hundred cycles
  initial begin
    #40000;
    n_fail++;
    results();
  end
endmodule
